// >>> rgb_pwm_regs.svh
// named constants for the single wire rgb pwm driver
// assumes a 50 mhz system clock and a synchronous serial line input
// Notes on behaviour
// R1 - three channels, each with 8-bit level
// R2 - reference ticks advance the brightness counter
// R3 - count one turns on non-zero channels
// R4 - channel on while counter within its level
// R5 - latch load clears counter, forces channels off
// R6 - off point follows gamma curve, not linear
// R7 - after reset channels stay off until loaded
// R8 - first two rising edges measure bit period
// R9 - bit period times bits, packet end, latch
// R10 - bit period accepted from 1.66 to 50 us
// R11 - period measurement shifts in two zero bits
// R12 - early second edge is one, late zero
// R13 - host sends thirty bits after measurement
// R14 - host ends each packet with low hold
// R15 - packet end locks register, forwards later input
// R16 - forwarded pulses regenerated with own timing
// R17 - write key 3a required for latch copy
// R18 - long low hold copies bits, restarts pwm
// R19 - channel fields at bits 23:16, 15:8, 7:0
// R20 - host sends msb first, nearest device first
// R21 - hold thresholds are bit period multiples
// R22 - brightness counter wraps and repeats frame
`ifndef RGB_PWM_REGS_SVH
`define RGB_PWM_REGS_SVH

`define SR_W 32
`define LEVEL_W 8
`define CNT_W 11
`define TMR_W 16
`define KEY_MSB 31
`define KEY_LSB 24
`define KEY_VALUE 8'h3a
`define CH0_MSB 23
`define CH0_LSB 16
`define CH1_MSB 15
`define CH1_LSB 8
`define CH2_MSB 7
`define CH2_LSB 0
`define CNT_ON_AT 11'h001
`define GAM_KNEE1 8'h08
`define GAM_KNEE2 8'h20
`define GAM_OFS1 14
`define GAM_OFS2 138
`define CLK_NS 20
`define BIT_MIN_NS 1660
`define BIT_MAX_NS 50000
`define FWD_PULSE_NS 125
`define EOS_MULT 3
`define LATCH_MULT 8
`define PWM_DIV 8
`define FWD_DEPTH 4
`define FWD_W 1

`endif

// >>> rgb_pwm_pkg.sv
// types shared by the single wire rgb pwm driver
// assumes nothing beyond a systemverilog compiler
package rgb_pwm_pkg;

  // serial link receive states
  typedef enum logic [1:0] {
    ST_WAIT_FIRST,
    ST_WAIT_SECOND,
    ST_BITS,
    ST_LOCKED
  } link_state_t;

endpackage : rgb_pwm_pkg

// >>> fwd_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module fwd_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0] mem_q [0:DEPTH-1];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // honest flags from the fill count
  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count updates
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + PW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + PW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage words, written only on an accepted push
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // R15 buffer never overflows
  property p_no_overflow;
    @(posedge clk) disable iff (sys_rst)
    cnt_q <= FULL_CNT;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth"); // R15

endmodule : fwd_fifo
`default_nettype wire

// >>> single_wire_rgb_pwm_driver.sv
// three channel gamma corrected pwm driver fed by a self-timed serial line
// assumes serial_line_in is synchronous to clk, one 50 mhz clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
`include "rgb_pwm_regs.svh"
module single_wire_rgb_pwm_driver
  import rgb_pwm_pkg::*;
#(
  parameter int CNT_W = `CNT_W,
  parameter int TMR_W = `TMR_W,
  parameter int EOS_MULT = `EOS_MULT,
  parameter int LATCH_MULT = `LATCH_MULT,
  parameter int PWM_DIV = `PWM_DIV,
  parameter int FWD_DEPTH = `FWD_DEPTH,
  parameter int FWD_W = `FWD_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_line_in,
  output logic serial_line_out,
  output logic [2:0] channel_on
);
  // timing counts derived from the printed times
  localparam int BIT_MIN_I = (`BIT_MIN_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int BIT_MAX_I = `BIT_MAX_NS / `CLK_NS;
  localparam int FWD_CYC_I = (`FWD_PULSE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam logic [TMR_W-1:0] BIT_MIN_CYC = TMR_W'(BIT_MIN_I);
  localparam logic [TMR_W-1:0] BIT_MAX_CYC = TMR_W'(BIT_MAX_I);
  localparam logic [4:0] FWD_CYC = 5'(FWD_CYC_I);
  localparam logic [4:0] FWD_SLOT = 5'(2 * FWD_CYC_I);
  localparam logic [3:0] DIV_LAST = 4'(PWM_DIV - 1);

  // off point of a level on the gamma curve
  function automatic logic [CNT_W-1:0] gamma_off(input logic [`LEVEL_W-1:0] lv);
    logic [CNT_W-1:0] w;
    w = CNT_W'(lv);
    if (lv < `GAM_KNEE1) begin
      return CNT_W'(w * 2);
    end else if (lv < `GAM_KNEE2) begin
      return CNT_W'(w * 4 - `GAM_OFS1);
    end else begin
      return CNT_W'(w * 8 - `GAM_OFS2);
    end
  endfunction : gamma_off

  link_state_t st_q, st_d;
  logic in_q;
  logic rise;
  logic [TMR_W-1:0] timer_q, timer_d, period_q, period_d;
  logic [TMR_W-1:0] half_thr, eos_thr, latch_thr;
  logic [`SR_W-1:0] sr_q, sr_d;
  logic bit_one_q, bit_one_d;
  logic latch_go, fwd_req, key_ok, load;
  logic [`LEVEL_W-1:0] level_q [0:2];
  logic [`LEVEL_W-1:0] level_d [0:2];
  logic [`LEVEL_W-1:0] sr_field [0:2];
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] chan_q, chan_d;
  logic [3:0] div_q, div_d;
  logic tick_q, tick_d;
  logic fwd_pend_q, fwd_pend_d;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FWD_W-1:0] fifo_out_data;
  logic [4:0] pg_q, pg_d;
  logic pulse_bit_q, pulse_bit_d;
  logic out_q, out_d;

  assign rise = serial_line_in && !in_q;
  assign half_thr = period_q >> 1;
  // R21 hold thresholds
  assign eos_thr = TMR_W'(period_q * EOS_MULT);
  assign latch_thr = TMR_W'(period_q * LATCH_MULT);
  // R17 key check
  assign key_ok = (sr_q[`KEY_MSB:`KEY_LSB] == `KEY_VALUE);
  assign load = latch_go && key_ok;
  // R19 channel field split
  assign sr_field[0] = sr_q[`CH0_MSB:`CH0_LSB];
  assign sr_field[1] = sr_q[`CH1_MSB:`CH1_LSB];
  assign sr_field[2] = sr_q[`CH2_MSB:`CH2_LSB];

  // serial receive: period measure, bit decode, lock and latch detection
  always_comb begin
    st_d = st_q;
    timer_d = (timer_q == '1) ? timer_q : timer_q + TMR_W'(1);
    period_d = period_q;
    sr_d = sr_q;
    bit_one_d = bit_one_q;
    latch_go = 1'b0;
    fwd_req = 1'b0;
    unique case (st_q)
      ST_WAIT_FIRST: begin
        timer_d = '0;
        if (rise) begin
          st_d = ST_WAIT_SECOND;
          timer_d = TMR_W'(1); // edge cycle counts, so timer equals spacing
        end
      end
      ST_WAIT_SECOND: begin
        if (rise) begin
          // R10 too short restarts measure
          if (timer_q < BIT_MIN_CYC) begin
            timer_d = TMR_W'(1);
          end else begin
            // R8 store bit period
            period_d = timer_q;
            // R11 two zero bits
            sr_d = {sr_q[`SR_W-3:0], 2'b00};
            timer_d = TMR_W'(1);
            bit_one_d = 1'b0;
            st_d = ST_BITS;
          end
        end else if (timer_q > BIT_MAX_CYC) begin
          // R10 too long abandons measure
          st_d = ST_WAIT_FIRST;
        end
      end
      ST_BITS: begin
        if (rise) begin
          // R12 early edge marks one
          if (timer_q < half_thr && !bit_one_q) begin
            bit_one_d = 1'b1;
          end else begin
            // R9 new bit starts
            sr_d = {sr_q[`SR_W-2:0], bit_one_q};
            bit_one_d = 1'b0;
            timer_d = TMR_W'(1);
          end
        end else if (!serial_line_in && timer_q >= eos_thr) begin
          // R15 lock on packet end
          sr_d = {sr_q[`SR_W-2:0], bit_one_q};
          bit_one_d = 1'b0;
          st_d = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (rise) begin
          // R15 forward later edges
          fwd_req = 1'b1;
          timer_d = TMR_W'(1);
        end else if (!serial_line_in && timer_q >= latch_thr) begin
          // R18 latch hold seen
          latch_go = 1'b1;
          timer_d = '0;
          st_d = ST_WAIT_FIRST;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_WAIT_FIRST;
      in_q <= 1'b0;
      timer_q <= '0;
      period_q <= '0;
      sr_q <= '0;
      bit_one_q <= 1'b0;
    end else begin
      st_q <= st_d;
      in_q <= serial_line_in;
      timer_q <= timer_d;
      period_q <= period_d;
      sr_q <= sr_d;
      bit_one_q <= bit_one_d;
    end
  end

  // reference tick divider, brightness counter, levels and channel drive
  always_comb begin
    div_d = (div_q == DIV_LAST) ? 4'h0 : div_q + 4'h1;
    tick_d = (div_q == DIV_LAST);
    cnt_d = cnt_q;
    chan_d = chan_q;
    for (int i = 0; i < 3; i++) begin
      level_d[i] = level_q[i];
    end
    if (load) begin
      // R1 R17 copy levels
      for (int i = 0; i < 3; i++) begin
        level_d[i] = sr_field[i];
      end
      // R5 restart and force off
      cnt_d = '0;
      chan_d = 3'h0;
    end else if (tick_q) begin
      // R2 R22 count and wrap
      cnt_d = cnt_q + CNT_W'(1);
      for (int i = 0; i < 3; i++) begin
        // R3 R4 R6 on window
        chan_d[i] = (level_q[i] != '0) && (cnt_d >= `CNT_ON_AT)
                    && (cnt_d < gamma_off(level_q[i]));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= 4'h0;
      tick_q <= 1'b0;
      cnt_q <= '0;
      // R7 reset to dark
      chan_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        level_q[i] <= '0;
      end
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      for (int i = 0; i < 3; i++) begin
        level_q[i] <= level_d[i];
      end
    end
  end

  // forwarded edges wait in a small buffer for the pulse generator
  fwd_fifo #(
    .W(FWD_W),
    .DEPTH(FWD_DEPTH)
  ) u_fwd_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fwd_pend_q),
    .in_data(FWD_W'(1)),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  assign fifo_out_ready = (pg_q == 5'h00);

  // R16 regenerated fixed pulses
  always_comb begin
    fwd_pend_d = (fwd_pend_q && !fifo_in_ready) || fwd_req;
    pg_d = (pg_q == 5'h00) ? 5'h00 : pg_q - 5'h01;
    pulse_bit_d = pulse_bit_q;
    if (fifo_out_valid && fifo_out_ready) begin
      pg_d = FWD_SLOT;
      pulse_bit_d = fifo_out_data[0];
    end
    out_d = (pg_d > FWD_CYC) && pulse_bit_d;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fwd_pend_q <= 1'b0;
      pg_q <= 5'h00;
      pulse_bit_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      fwd_pend_q <= fwd_pend_d;
      pg_q <= pg_d;
      pulse_bit_q <= pulse_bit_d;
      out_q <= out_d;
    end
  end

  assign serial_line_out = out_q;
  assign channel_on = chan_q;

  // checks on the behaviour above
  property p_load_clears;
    @(posedge clk) disable iff (sys_rst)
    load |=> (cnt_q == '0) && (chan_q == 3'h0);
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("load did not clear pwm"); // R5

  property p_on_needs_count;
    @(posedge clk) disable iff (sys_rst)
    (chan_q != 3'h0) |-> (cnt_q >= `CNT_ON_AT);
  endproperty
  a_on_needs_count: assert property (p_on_needs_count) else $error("channel on at count zero"); // R3

  property p_zero_dark;
    @(posedge clk) disable iff (sys_rst)
    (level_q[0] == '0) |-> !chan_q[0];
  endproperty
  a_zero_dark: assert property (p_zero_dark) else $error("zero level channel lit"); // R7

  property p_gamma_window;
    @(posedge clk) disable iff (sys_rst)
    chan_q[1] |-> (cnt_q < gamma_off(level_q[1]));
  endproperty
  a_gamma_window: assert property (p_gamma_window) else $error("channel past off point"); // R6

  property p_count_step;
    @(posedge clk) disable iff (sys_rst)
    (tick_q && !load) |=> (cnt_q == CNT_W'($past(cnt_q) + CNT_W'(1)));
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step"); // R2

  property p_period_store;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_WAIT_SECOND && rise && timer_q >= BIT_MIN_CYC)
      |=> (period_q == $past(timer_q)) && (st_q == ST_BITS) && (sr_q[1:0] == 2'b00);
  endproperty
  a_period_store: assert property (p_period_store) else $error("period not stored"); // R8

  property p_early_one;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_BITS && rise && timer_q < half_thr && !bit_one_q) |=> bit_one_q;
  endproperty
  a_early_one: assert property (p_early_one) else $error("early edge not one"); // R12

  property p_bad_key_keeps;
    @(posedge clk) disable iff (sys_rst)
    (latch_go && !key_ok) |=> (level_q[0] == $past(level_q[0]))
      && (level_q[2] == $past(level_q[2]));
  endproperty
  a_bad_key_keeps: assert property (p_bad_key_keeps) else $error("bad key changed level"); // R17

  property p_field_map;
    @(posedge clk) disable iff (sys_rst)
    load |=> (level_q[0] == $past(sr_q[`CH0_MSB:`CH0_LSB]))
      && (level_q[2] == $past(sr_q[`CH2_MSB:`CH2_LSB]));
  endproperty
  a_field_map: assert property (p_field_map) else $error("field mapping wrong"); // R19

  property p_pulse_width;
    @(posedge clk) disable iff (sys_rst)
    $rose(out_q) |-> out_q [*7] ##1 !out_q;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("forward pulse width wrong"); // R16

  property p_forward;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_LOCKED && rise) |=> fwd_pend_q;
  endproperty
  a_forward: assert property (p_forward) else $error("locked edge not forwarded"); // R15

  property p_period_range;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_BITS) |-> (period_q >= BIT_MIN_CYC) && (period_q <= BIT_MAX_CYC + TMR_W'(1));
  endproperty
  a_period_range: assert property (p_period_range) else $error("period out of range"); // R10

  c_load: cover property (@(posedge clk) disable iff (sys_rst) load);
  c_lock: cover property (@(posedge clk) disable iff (sys_rst)
    st_q == ST_BITS ##1 st_q == ST_LOCKED);
  c_fwd_pulse: cover property (@(posedge clk) disable iff (sys_rst) $rose(out_q));
  c_lit: cover property (@(posedge clk) disable iff (sys_rst) chan_q == 3'h7);

endmodule : single_wire_rgb_pwm_driver
`default_nettype wire

// >>> host_model.sv
// host side model that drives the single wire serial line
// assumes a free running clk; the line changes 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic serial_line_in
);
  // line idles low as with the input pull-down
  initial serial_line_in = 1'b0;

  // wait n edges, then step just past the edge
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // one short high pulse makes one rising edge, takes 3 cycles
  task automatic pulse();
    serial_line_in = 1'b1;
    idle(3);
    serial_line_in = 1'b0;
  endtask : pulse

  // stray edge too close to the next one, so measuring restarts
  task automatic glitch();
    pulse();
    idle(40);
  endtask : glitch

  // one packet msb first, period p cycles
  task automatic send_packet(input logic [31:0] bits, input int p);
    int ofs;
    // first two edges give the period and two zeros
    pulse();
    idle(p - 3);
    for (int i = 29; i >= 0; i--) begin
      pulse();
      if (bits[i]) begin
        ofs = $urandom_range(p / 2 - 3, 4);
        idle(ofs - 3);
        pulse();
        idle(p - ofs - 3);
      end else begin
        idle(p - 3);
      end
    end
  endtask : send_packet

  // packet end hold, at least 3 periods low
  task automatic packet_end_hold(input int p);
    idle(3 * p);
  endtask : packet_end_hold

  // latch hold, well over 8 periods after the last edge
  task automatic latch(input int p);
    idle(6 * p);
  endtask : latch
endmodule : host_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the single wire rgb pwm driver
// assumes the host model drives the serial line; 50 mhz clk
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int PWM_DIV = 2;
  localparam int FRAME = 2048 * PWM_DIV;
  logic clk;
  logic sys_rst;
  logic serial_line_in;
  logic serial_line_out;
  logic [2:0] channel_on;
  int num_errors;
  int n_tests;
  int rise_cnt [3];
  logic [7:0] cur_lv [3];
  logic [15:0] width_q [3][$];
  logic [15:0] fwd_q [$];
  logic [15:0] fw;

  host_model HOST (
    .clk(clk),
    .serial_line_in(serial_line_in)
  );

  single_wire_rgb_pwm_driver #(.PWM_DIV(PWM_DIV)) DUT (
    .clk(clk),
    .sys_rst(sys_rst),
    .serial_line_in(serial_line_in),
    .serial_line_out(serial_line_out),
    .channel_on(channel_on)
  );

  // free running clock, 20 ns period
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // print counts and verdict, then stop
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // expected on width in clk cycles for one level
  function automatic logic [15:0] exp_width(input logic [7:0] lv);
    int off;
    if (lv < 8) off = 2 * lv;
    else if (lv < 32) off = 4 * lv - 14;
    else off = 8 * lv - 138;
    // on from count 1 until the off point
    return 16'((off - 1) * PWM_DIV);
  endfunction : exp_width

  // measure channel pulses that start while a note is waiting
  for (genvar n = 0; n < 3; n++) begin : g_mon
    logic [15:0] w;
    logic armed;
    initial w = 16'h0000;
    initial armed = 1'b0;
    always @(posedge clk) begin
      if (channel_on[n] === 1'b1) begin
        if (w == 0) begin
          armed = (width_q[n].size() > 0);
          rise_cnt[n]++;
        end
        w++;
      end else if (w != 0) begin
        if (armed) check(w, width_q[n].pop_front());
        w = 0;
      end
    end
  end

  // every forwarded pulse must have been noted beforehand
  initial fw = 16'h0000;
  always @(posedge clk) begin
    if (serial_line_out === 1'b1) begin
      fw++;
    end else if (fw != 0) begin
      check(fw, fwd_q.size() > 0 ? fwd_q.pop_front() : 16'hffff);
      fw = 0;
    end
  end

  // one packet, optional forwarded packet, latch, then watch two frames
  task automatic run_test(input int t, input int p, input logic [7:0] key,
                          input logic [23:0] lv, input bit fwd, input bit glt);
    logic [31:0] pkt;
    logic [31:0] nxt;
    pkt = {key, lv};
    nxt = ~pkt;
    if (glt) HOST.glitch();
    HOST.send_packet(pkt, p);
    HOST.packet_end_hold(p);
    if (fwd) begin
      // one regenerated pulse per edge while locked
      repeat (31 + $countones(nxt[29:0])) fwd_q.push_back(16'h0007);
      HOST.send_packet(nxt, p);
      HOST.packet_end_hold(p);
    end
    HOST.latch(p);
    // only a matching key loads the channel fields
    if (key === 8'h3a) begin
      cur_lv[0] = pkt[23:16];
      cur_lv[1] = pkt[15:8];
      cur_lv[2] = pkt[7:0];
    end
    for (int n = 0; n < 3; n++) begin
      rise_cnt[n] = 0;
      if (cur_lv[n] != 8'h00) width_q[n].push_back(exp_width(cur_lv[n]));
    end
    HOST.idle(2 * FRAME + 200);
    for (int n = 0; n < 3; n++) begin
      check(16'(width_q[n].size()), 16'h0000);
      if (cur_lv[n] === 8'h00) check(16'(rise_cnt[n]), 16'h0000);
    end
    check(16'(fwd_q.size()), 16'h0000);
    $display("test %0d done", t);
  endtask : run_test

  // main sequence
  initial begin
    sys_rst = 1'b1;
    num_errors = 0;
    n_tests = 0;
    for (int n = 0; n < 3; n++) begin
      cur_lv[n] = 8'h00;
      rise_cnt[n] = 0;
    end
    void'($urandom(32'hf69e0d68));
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    HOST.idle(200);
    check({13'h0000, channel_on}, 16'h0000);
    run_test(1, 83, 8'h3a, {8'h01, 8'hff, 8'h00}, 1'b0, 1'b1);
    run_test(2, 300, 8'h3a, {8'h07, 8'h08, 8'h1f}, 1'b0, 1'b0);
    run_test(3, 83 + $urandom_range(217), 8'h3a,
             {8'h20, 8'($urandom), 8'($urandom)}, 1'b0, 1'b0);
    run_test(4, 150, 8'h3b, 24'($urandom), 1'b0, 1'b0);
    run_test(5, 100, 8'h3a, 24'($urandom), 1'b1, 1'b0);
    give_verdict();
  end

  // cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
